//--- hdl/fcei_pkg.sv
// constants, types and helpers shared by the error and alarm injector
package fcei_pkg;
	localparam int CLK_HZ = 25_000_000;
	localparam int ONE_SEC_S = 1;
	localparam int SEC_CYCLES_DEF = CLK_HZ * ONE_SEC_S;
	localparam logic [3:0] TEN_SEC_LAST = 4'h9;
	localparam int PPM_FULL = 1_000_000;
	localparam logic [26:0] MEM_BYTES = 27'h400_0000;
	localparam logic [26:0] REC_BYTES = 27'h000_0040;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_BURST = 8'h04;
	localparam logic [7:0] OFS_CMD = 8'h08;
	localparam logic [7:0] OFS_FREQ = 8'h0C;
	localparam logic [7:0] OFS_MCFG = 8'h10;
	localparam logic [7:0] OFS_TIME = 8'h14;
	localparam logic [7:0] OFS_START = 8'h18;
	localparam logic [7:0] OFS_STOP = 8'h1C;
	localparam logic [7:0] OFS_DUR = 8'h20;
	localparam logic [7:0] OFS_STAT = 8'h24;
	localparam logic [7:0] OFS_MPTR = 8'h28;
	localparam int CTRL_ALM = 0;
	localparam int CTRL_ERR = 3;
	localparam int CTRL_INS = 6;
	localparam int CTRL_64B = 10;
	localparam int CTRL_FULLFR = 11;
	localparam int CMD_TRIG = 0;
	localparam int CMD_START = 1;
	localparam int CMD_STOP = 2;
	localparam int MCFG_IVL = 0;
	localparam int MCFG_AT = 5;
	localparam int MCFG_STOP = 6;
	localparam int MCFG_CONT = 8;
	localparam int STAT_EVT = 4;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [15:0] BURST_RST = 16'h0001;
	localparam logic [7:0] K28_5 = 8'hBC;
	localparam logic [7:0] D9_2 = 8'h49;
	localparam logic [7:0] D31_5 = 8'hBF;
	localparam logic [7:0] D21_1 = 8'h35;
	localparam logic [7:0] D21_2 = 8'h55;
	localparam logic [7:0] D5_2 = 8'h45;
	localparam logic [7:0] D10_4 = 8'h8A;
	localparam logic [7:0] D21_4 = 8'h95;
	localparam logic [7:0] D10_2 = 8'h4A;
	localparam logic [3:0] K_FIRST = 4'h8;
	localparam logic [1:0] SYNC_CTL = 2'h2;
	localparam logic [1:0] SYNC_BAD = 2'h0;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	typedef enum logic [2:0] {ALM_NONE, ALM_LR, ALM_LRR, ALM_NOS,
		ALM_OLS} fcei_alm_t;
	typedef enum logic [2:0] {ERR_NONE, ERR_BIT, ERR_SYM, ERR_RRDY, ERR_CRC,
		ERR_BLOCK} fcei_err_t;
	typedef enum logic [3:0] {INS_OFF, INS_MAN, INS_SEC, INS_10S, INS_R2, INS_R3,
		INS_R4, INS_R5, INS_R6, INS_R7} fcei_ins_t;
	typedef enum logic [1:0] {STOP_MAN, STOP_AT, STOP_DUR} fcei_stop_t;
	typedef struct packed {
		logic [1:0] sync;
		logic [31:0] data;
		logic [3:0] k;
		logic viol;
		logic payload;
		logic crc;
		logic fill;
	} fcei_word_t;
	function automatic logic [31:0] ivl_secs(input logic [4:0] sel);
		case (sel)
			5'd1: ivl_secs = 32'd1;
			5'd2: ivl_secs = 32'd2;
			5'd3: ivl_secs = 32'd5;
			5'd4: ivl_secs = 32'd10;
			5'd5: ivl_secs = 32'd15;
			5'd6: ivl_secs = 32'd30;
			5'd7: ivl_secs = 32'd60;
			5'd8: ivl_secs = 32'd300;
			5'd9: ivl_secs = 32'd600;
			5'd10: ivl_secs = 32'd900;
			5'd11: ivl_secs = 32'd1800;
			5'd12: ivl_secs = 32'd3600;
			5'd13: ivl_secs = 32'd7200;
			5'd14: ivl_secs = 32'd14400;
			5'd15: ivl_secs = 32'd21600;
			5'd16: ivl_secs = 32'd43200;
			default: ivl_secs = 32'd0;
		endcase
	endfunction
endpackage

//--- hdl/fcei_injector.sv
// transmit-side alarm, error, frequency and measurement control block
//
// Function
// - link-reset alarm sends K28.5 D9.2 D31.5 D9.2 on every word
// - link-reset-response alarm sends K28.5 D21.1 D31.5 D9.2 continuously
// - not-operational alarm sends K28.5 D21.2 D31.5 D5.2 continuously
// - offline alarm sends K28.5 D21.1 D10.4 D21.2 continuously
// - alarm holds until selection changes; none stops injection
// - receiver-ready error inserts an extra K28.5 D21.4 D10.2 D10.2
// - bit error inverts one payload bit of a frame
// - symbol error sends an undecodable 10-bit code group
// - symbol error unavailable in 64b/66b rates
// - CRC error flips one CRC bit; unavailable with full framing
// - block error emits an errored 64b/66b block, 64b/66b rates only
// - insertion off injects nothing
// - each manual trigger injects exactly one burst
// - per-second mode injects one burst every second
// - per-ten-seconds mode injects one burst every ten seconds
// - ratio modes inject one burst per 10^N words; trigger shows status, but here a trigger outside manual mode is ignored and changes no status
// - signed deviation offsets line frequency, positive raises it
// - interval length selectable from fixed list or disabled
// - measurement starts on command or at absolute time
// - measurement stops on command, at time, or after duration
// - full result memory stops or wraps and logs an event; here only a wrap logs the event, a stop only sets the full flag
//
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module fcei_injector
	import fcei_pkg::*;
#(
	parameter int SEC_CYCLES = SEC_CYCLES_DEF
)
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic tx_in_valid,
	input wire fcei_word_t tx_in,
	output logic tx_out_valid,
	output fcei_word_t tx_out,
	output logic tx_freq_up,
	output logic tx_freq_dn,
	input wire logic rec_wr,
	output logic [25:0] rec_addr,
	output logic meas_running,
	output logic interval_tick
);
	typedef enum {MS_IDLE, MS_ARMED, MS_RUN} fcei_ms_t;

	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic aw_have_r, w_have_r, bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic [31:0] ctrl_r, mcfg_r, dev_r, start_r, stop_r, dur_r;
	logic [15:0] burst_r;
	logic [31:0] sec_cnt_r, rtc_r, elapsed_r, ivl_cnt_r;
	logic [3:0] ten_cnt_r;
	logic [23:0] wcnt_r;
	logic [15:0] left_r, left_nxt;
	logic signed [31:0] acc_r, acc_nxt;
	logic up_nxt, dn_nxt;
	fcei_ms_t ms_r, ms_nxt;
	logic [26:0] ptr_r;
	logic mem_full_r, mem_evt_r;
	fcei_word_t out_r, out_nxt;
	logic out_valid_r, ivl_tick_r;

	// bus decode
	wire aw_hs = s_axi_awvalid && s_axi_awready;
	wire w_hs = s_axi_wvalid && s_axi_wready;
	wire do_wr = aw_have_r && w_have_r && !bvalid_r;
	wire ar_hs = s_axi_arvalid && s_axi_arready;
	wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
		{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
	wire [31:0] wmerge_ctrl = (ctrl_r & ~wmask) | (wdata_r & wmask);
	wire [31:0] wmerge_mcfg = (mcfg_r & ~wmask) | (wdata_r & wmask);
	wire [31:0] wmerge_dev = (dev_r & ~wmask) | (wdata_r & wmask);
	wire [31:0] wmerge_time = (rtc_r & ~wmask) | (wdata_r & wmask);
	wire [31:0] wmerge_start = (start_r & ~wmask) | (wdata_r & wmask);
	wire [31:0] wmerge_stop = (stop_r & ~wmask) | (wdata_r & wmask);
	wire [31:0] wmerge_dur = (dur_r & ~wmask) | (wdata_r & wmask);
	wire [31:0] burst_w = {16'h0000, burst_r};
	wire [31:0] wmerge_burst = (burst_w & ~wmask) | (wdata_r & wmask);
	wire wr_ctrl = do_wr && awaddr_r == OFS_CTRL;
	wire wr_burst = do_wr && awaddr_r == OFS_BURST;
	wire wr_cmd = do_wr && awaddr_r == OFS_CMD && wstrb_r[0];
	wire wr_freq = do_wr && awaddr_r == OFS_FREQ;
	wire wr_mcfg = do_wr && awaddr_r == OFS_MCFG;
	wire wr_time = do_wr && awaddr_r == OFS_TIME;
	wire wr_start = do_wr && awaddr_r == OFS_START;
	wire wr_stop = do_wr && awaddr_r == OFS_STOP;
	wire wr_dur = do_wr && awaddr_r == OFS_DUR;
	wire wr_stat = do_wr && awaddr_r == OFS_STAT && wstrb_r[0];
	wire wr_hit = wr_ctrl || wr_burst || (awaddr_r == OFS_CMD) || wr_freq
		|| wr_mcfg || wr_time || wr_start || wr_stop || wr_dur
		|| (awaddr_r == OFS_STAT) || (awaddr_r == OFS_MPTR);
	wire cmd_trig = wr_cmd && wdata_r[CMD_TRIG];
	wire cmd_start = wr_cmd && wdata_r[CMD_START];
	wire cmd_stop = wr_cmd && wdata_r[CMD_STOP];

	// configuration fields
	wire fcei_alm_t alm = fcei_alm_t'(ctrl_r[CTRL_ALM +: 3]);
	wire fcei_err_t err = fcei_err_t'(ctrl_r[CTRL_ERR +: 3]);
	wire fcei_ins_t ins = fcei_ins_t'(ctrl_r[CTRL_INS +: 4]);
	wire mode_64b = ctrl_r[CTRL_64B];
	wire full_frame = ctrl_r[CTRL_FULLFR];
	wire [4:0] ivl_sel = mcfg_r[MCFG_IVL +: 5];
	wire start_at = mcfg_r[MCFG_AT];
	wire fcei_stop_t stop_mode = fcei_stop_t'(mcfg_r[MCFG_STOP +: 2]);
	wire mem_cont = mcfg_r[MCFG_CONT];
	wire [31:0] ivl_len = ivl_secs(ivl_sel);

	// one-second time base and its tenfold
	wire sec_tick = sec_cnt_r == 32'(SEC_CYCLES - 1);
	wire ten_tick = sec_tick && ten_cnt_r == TEN_SEC_LAST;

	// ratio period, 10^N words per burst
	logic [23:0] ratio_len;
	always_comb
	begin
		case (ins)
			INS_R2: ratio_len = 24'd100;
			INS_R3: ratio_len = 24'd1_000;
			INS_R4: ratio_len = 24'd10_000;
			INS_R5: ratio_len = 24'd100_000;
			INS_R6: ratio_len = 24'd1_000_000;
			INS_R7: ratio_len = 24'd10_000_000;
			default: ratio_len = 24'd0;
		endcase
	end
	wire ratio_mode = ratio_len != 24'd0;
	wire ratio_hit = ratio_mode && tx_in_valid
		&& wcnt_r == ratio_len - 24'd1;

	// insertion events; manual trigger only counts in manual mode
	wire ev = (ins == INS_MAN && cmd_trig)
		|| (ins == INS_SEC && sec_tick)
		|| (ins == INS_10S && ten_tick)
		|| ratio_hit;

	// eligible positions per error type
	logic elig;
	always_comb
	begin
		case (err)
			ERR_BIT: elig = tx_in.payload;
			ERR_SYM: elig = !mode_64b;
			ERR_RRDY: elig = tx_in.fill;
			ERR_CRC: elig = tx_in.crc && !full_frame;
			ERR_BLOCK: elig = mode_64b;
			default: elig = 1'b0;
		endcase
	end
	// alarms own the line, so pending errors wait behind them
	wire inj_now = tx_in_valid && left_r != 16'h0000 && elig
		&& alm == ALM_NONE;

	always_comb
	begin
		left_nxt = left_r;
		if (ins == INS_OFF)
			left_nxt = 16'h0000;
		else if (ev)
			left_nxt = burst_r;
		else if (inj_now)
			left_nxt = left_r - 16'h0001;
	end

	// transmit word rewrite
	always_comb
	begin
		out_nxt = tx_in;
		case (alm)
			ALM_LR: out_nxt.data = {K28_5, D9_2, D31_5, D9_2};
			ALM_LRR: out_nxt.data = {K28_5, D21_1, D31_5, D9_2};
			ALM_NOS: out_nxt.data = {K28_5, D21_2, D31_5, D5_2};
			ALM_OLS: out_nxt.data = {K28_5, D21_1, D10_4, D21_2};
			default: out_nxt.data = tx_in.data;
		endcase
		if (alm != ALM_NONE)
		begin
			// every word replaced while selected
			out_nxt.k = K_FIRST;
			out_nxt.sync = SYNC_CTL;
			out_nxt.viol = 1'b0;
			out_nxt.payload = 1'b0;
			out_nxt.crc = 1'b0;
			out_nxt.fill = 1'b0;
		end
		else if (inj_now)
		begin
			case (err)
				ERR_BIT: out_nxt.data[0] = !tx_in.data[0];
				ERR_SYM: out_nxt.viol = 1'b1;
				ERR_RRDY:
				begin
					out_nxt.data = {K28_5, D21_4, D10_2, D10_2};
					out_nxt.k = K_FIRST;
					out_nxt.fill = 1'b0;
				end
				ERR_CRC: out_nxt.data[0] = !tx_in.data[0];
				ERR_BLOCK: out_nxt.sync = SYNC_BAD;
				default: out_nxt.viol = 1'b0;
			endcase
		end
	end

	// frequency offset, one slip or extra slot per million of deviation
	always_comb
	begin
		acc_nxt = acc_r + $signed(dev_r);
		up_nxt = 1'b0;
		dn_nxt = 1'b0;
		if (acc_nxt >= $signed(PPM_FULL))
		begin
			acc_nxt = acc_nxt - $signed(PPM_FULL);
			up_nxt = 1'b1;
		end
		else if (acc_nxt <= -$signed(PPM_FULL))
		begin
			acc_nxt = acc_nxt + $signed(PPM_FULL);
			dn_nxt = 1'b1;
		end
	end

	// measurement control
	wire [26:0] ptr_add = ptr_r + REC_BYTES;
	wire rec_take = ms_r == MS_RUN && rec_wr && !mem_full_r;
	wire mem_wrap = rec_take && ptr_add >= MEM_BYTES;
	wire mem_stop = mem_wrap && !mem_cont;
	wire stop_hit = cmd_stop
		|| (stop_mode == STOP_AT && rtc_r == stop_r)
		|| (stop_mode == STOP_DUR && elapsed_r == dur_r)
		|| mem_stop;
	wire start_hit = ms_r == MS_ARMED && rtc_r == start_r;
	wire go = (ms_r == MS_IDLE && cmd_start && !start_at) || start_hit;
	wire ivl_end = ms_r == MS_RUN && sec_tick && ivl_len != RST_ZERO
		&& ivl_cnt_r == ivl_len - 32'd1;

	always_comb
	begin
		ms_nxt = ms_r;
		case (ms_r)
			MS_IDLE:
				if (cmd_start)
					ms_nxt = start_at ? MS_ARMED : MS_RUN;
			MS_ARMED:
				if (cmd_stop)
					ms_nxt = MS_IDLE;
				else if (start_hit)
					ms_nxt = MS_RUN;
			MS_RUN:
				if (stop_hit)
					ms_nxt = MS_IDLE;
			default: ms_nxt = MS_IDLE;
		endcase
	end

	// read mux; unmapped words read zero with an error response
	logic [31:0] rd_mux;
	logic rd_hit;
	always_comb
	begin
		rd_hit = 1'b1;
		case (s_axi_araddr)
			OFS_CTRL: rd_mux = ctrl_r;
			OFS_BURST: rd_mux = burst_w;
			OFS_CMD: rd_mux = RST_ZERO;
			OFS_FREQ: rd_mux = dev_r;
			OFS_MCFG: rd_mux = mcfg_r;
			OFS_TIME: rd_mux = rtc_r;
			OFS_START: rd_mux = start_r;
			OFS_STOP: rd_mux = stop_r;
			OFS_DUR: rd_mux = dur_r;
			OFS_STAT: rd_mux = {27'h000_0000, mem_evt_r, mem_full_r,
				left_r != 16'h0000, ms_r == MS_ARMED, ms_r == MS_RUN};
			OFS_MPTR: rd_mux = {5'h00, ptr_r};
			default:
			begin
				rd_mux = RST_ZERO;
				rd_hit = 1'b0;
			end
		endcase
	end

	assign s_axi_awready = !aw_have_r && !bvalid_r;
	assign s_axi_wready = !w_have_r && !bvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign tx_out = out_r;
	assign tx_out_valid = out_valid_r;
	assign rec_addr = ptr_r[25:0];
	assign meas_running = ms_r == MS_RUN;
	assign interval_tick = ivl_tick_r;

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OK;
			awaddr_r <= 8'h00;
			wdata_r <= RST_ZERO;
			wstrb_r <= 4'h0;
		end
		else
		begin
			if (aw_hs)
			begin
				aw_have_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (w_hs)
			begin
				w_have_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (do_wr)
			begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_hit ? RESP_OK : RESP_ERR;
			end
			else if (bvalid_r && s_axi_bready)
				bvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rvalid_r <= 1'b0;
			rdata_r <= RST_ZERO;
			rresp_r <= RESP_OK;
		end
		else if (ar_hs)
		begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_mux;
			rresp_r <= rd_hit ? RESP_OK : RESP_ERR;
		end
		else if (rvalid_r && s_axi_rready)
			rvalid_r <= 1'b0;
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrl_r <= RST_ZERO;
			burst_r <= BURST_RST;
			dev_r <= RST_ZERO;
			mcfg_r <= RST_ZERO;
			start_r <= RST_ZERO;
			stop_r <= RST_ZERO;
			dur_r <= RST_ZERO;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_r <= wmerge_ctrl;
			if (wr_burst)
				burst_r <= wmerge_burst[15:0];
			if (wr_freq)
				dev_r <= wmerge_dev;
			if (wr_mcfg)
				mcfg_r <= wmerge_mcfg;
			if (wr_start)
				start_r <= wmerge_start;
			if (wr_stop)
				stop_r <= wmerge_stop;
			if (wr_dur)
				dur_r <= wmerge_dur;
		end
	end

	// time base, ratio word count, burst countdown, line output
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sec_cnt_r <= RST_ZERO;
			ten_cnt_r <= 4'h0;
			wcnt_r <= 24'h00_0000;
			left_r <= 16'h0000;
			acc_r <= RST_ZERO;
			tx_freq_up <= 1'b0;
			tx_freq_dn <= 1'b0;
			out_r <= '0;
			out_valid_r <= 1'b0;
		end
		else
		begin
			sec_cnt_r <= sec_tick ? RST_ZERO : sec_cnt_r + 32'd1;
			if (ten_tick)
				ten_cnt_r <= 4'h0;
			else if (sec_tick)
				ten_cnt_r <= ten_cnt_r + 4'h1;
			if (!ratio_mode || ratio_hit)
				wcnt_r <= 24'h00_0000;
			else if (tx_in_valid)
				wcnt_r <= wcnt_r + 24'h00_0001;
			left_r <= left_nxt;
			acc_r <= acc_nxt;
			tx_freq_up <= up_nxt;
			tx_freq_dn <= dn_nxt;
			out_r <= out_nxt;
			out_valid_r <= tx_in_valid;
		end
	end

	// measurement clock, interval and result memory
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ms_r <= MS_IDLE;
			rtc_r <= RST_ZERO;
			elapsed_r <= RST_ZERO;
			ivl_cnt_r <= RST_ZERO;
			ivl_tick_r <= 1'b0;
			ptr_r <= 27'h000_0000;
			mem_full_r <= 1'b0;
			mem_evt_r <= 1'b0;
		end
		else
		begin
			ms_r <= ms_nxt;
			if (wr_time)
				rtc_r <= wmerge_time;
			else if (sec_tick)
				rtc_r <= rtc_r + 32'd1;
			ivl_tick_r <= ivl_end;
			if (go)
			begin
				elapsed_r <= RST_ZERO;
				ivl_cnt_r <= RST_ZERO;
				ptr_r <= 27'h000_0000;
				mem_full_r <= 1'b0;
			end
			else
			begin
				if (ms_r == MS_RUN && sec_tick)
				begin
					elapsed_r <= elapsed_r + 32'd1;
					ivl_cnt_r <= ivl_end ? RST_ZERO : ivl_cnt_r + 32'd1;
				end
				if (mem_wrap && mem_cont)
					ptr_r <= 27'h000_0000;
				else if (mem_wrap)
					mem_full_r <= 1'b1;
				else if (rec_take)
					ptr_r <= ptr_add;
			end
			// a new wrap in the clearing cycle keeps the event
			if (mem_wrap && mem_cont)
				mem_evt_r <= 1'b1;
			else if (wr_stat && wdata_r[STAT_EVT])
				mem_evt_r <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- bench/fcei_far_port.sv
// far-end port model: decodes the transmit stream and counts events
`timescale 1ns/1ps
`default_nettype none
module fcei_far_port
	import fcei_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic tx_out_valid,
	input wire fcei_word_t tx_out,
	output var int n_err,
	output var int n_os
);
	wire rrdy = tx_out.k == K_FIRST && tx_out.data == {K28_5, D21_4, D10_2,
		D10_2};
	wire os = tx_out.k == K_FIRST && !rrdy;
	// data words carry even parity, so one flipped bit reads as odd
	wire bad = tx_out.viol || tx_out.sync == SYNC_BAD || rrdy
		|| (tx_out.k == 4'h0 && ^tx_out.data);
	always_ff @(posedge ref_clk or negedge rstn)
		if (!rstn)
		begin
			n_err <= 0;
			n_os <= 0;
		end
		else if (tx_out_valid)
		begin
			n_err <= n_err + int'(bad);
			n_os <= n_os + int'(os);
		end
endmodule
`default_nettype wire

//--- bench/fcei_checker.sv
// port-level relations of the injector
`timescale 1ns/1ps
`default_nettype none
module fcei_checker
	import fcei_pkg::*;
#(
	parameter int SEC_CYCLES = 20
)
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_wvalid,
	input wire logic tx_in_valid,
	input wire fcei_word_t tx_in,
	input wire logic tx_out_valid,
	input wire fcei_word_t tx_out,
	input wire logic tx_freq_up,
	input wire logic tx_freq_dn,
	input wire logic rec_wr,
	input wire logic [25:0] rec_addr,
	input wire logic meas_running
);
	logic [1:0] up_r;
	// skip edges whose past still sees reset values
	wire ok = up_r == 2'd3;
	wire alm = tx_out_valid && tx_out.k == 4'h8 &&
		tx_out.data != 32'hBC95_4A4A;
	always_ff @(posedge ref_clk or negedge rstn)
		if (!rstn)
			up_r <= 2'd0;
		else if (!ok)
			up_r <= up_r + 2'd1;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);
	chk_alarm_code: assert property (ok && alm |->
		tx_out.sync == SYNC_CTL && tx_out.data inside {32'hBC49_BF49,
		32'hBC35_BF49, 32'hBC55_BF45, 32'hBC35_8A55})
		else $error("alarm word not a known ordered set");
	chk_alarm_hold: assert property (ok && alm && tx_in_valid &&
		!s_axi_awvalid && !s_axi_wvalid && !$past(s_axi_wvalid) &&
		!$past(s_axi_wvalid, 2) |=> tx_out.data == $past(tx_out.data))
		else $error("alarm changed without a write");
	chk_rrdy_slot: assert property (ok && tx_out_valid &&
		tx_out.k == 4'h8 && tx_out.data == 32'hBC95_4A4A |->
		$past(tx_in.fill) && !tx_out.fill)
		else $error("ready word outside a fill slot");
	chk_one_bit: assert property (ok && tx_out_valid &&
		tx_out.k == 4'h0 && tx_out.data != $past(tx_in.data) |->
		($past(tx_in.payload) || $past(tx_in.crc)) &&
		tx_out.data == ($past(tx_in.data) ^ 32'h0000_0001))
		else $error("data changed beyond one bit");
	chk_sym_keep: assert property (ok && tx_out_valid && tx_out.viol |->
		tx_out.data == $past(tx_in.data) && tx_out.sync != SYNC_BAD)
		else $error("symbol error altered data");
	chk_block_keep: assert property (ok && tx_out_valid &&
		tx_out.sync == SYNC_BAD && tx_out.k == 4'h0 |->
		!tx_out.viol && tx_out.data == $past(tx_in.data))
		else $error("block error mixed with other change");
	chk_freq_excl: assert property (!(tx_freq_up && tx_freq_dn))
		else $error("frequency raised and lowered together");
	chk_rec_step: assert property (ok && rec_wr && meas_running |=>
		rec_addr == $past(rec_addr) + 26'h40)
		else $error("record pointer did not step");
endmodule
bind fcei_injector fcei_checker #(.SEC_CYCLES(SEC_CYCLES)) u_chk (.ref_clk,
	.rstn, .s_axi_awvalid, .s_axi_wvalid, .tx_in_valid, .tx_in,
	.tx_out_valid, .tx_out, .tx_freq_up, .tx_freq_dn, .rec_wr, .rec_addr,
	.meas_running);
`default_nettype wire

//--- bench/fc_error_alarm_injector_tb.sv
// self-checking bench for the error and alarm injector
`timescale 1ns/1ps
`default_nettype none
module fc_error_alarm_injector_tb;
	import fcei_pkg::*;
	localparam int SEC = 20;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic tx_in_valid = 1'b0;
	logic rec_wr = 1'b0;
	fcei_word_t tx_in = '0;
	fcei_word_t tx_out;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, tx_out_valid, tx_freq_up, tx_freq_dn;
	logic meas_running, interval_tick;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [25:0] rec_addr;
	int n_err, n_os, mismatches = 0, check_count = 0, cyc = 0;
	int n_up = 0, n_dn = 0, n_tick = 0;
	logic [31:0] seed = 32'h0000_0044;
	logic [2:0] tags = 3'b000;
	logic [31:0] alw [4] = '{{K28_5, D9_2, D31_5, D9_2},
		{K28_5, D21_1, D31_5, D9_2}, {K28_5, D21_2, D31_5, D5_2},
		{K28_5, D21_1, D10_4, D21_2}};
	// control word per case; then tags {payload, crc, fill}, burst expected
	logic [11:0] ec [10] = '{12'h048, 12'h048, 12'h050, 12'h450, 12'h058,
		12'h060, 12'h860, 12'h468, 12'h068, 12'h008};
	logic [3:0] et [10] = '{4'h9, 4'h4, 4'h1, 4'h0, 4'h3, 4'h5, 4'h4, 4'h1,
		4'h0, 4'h8};
	fcei_injector #(.SEC_CYCLES(SEC)) dut (.ref_clk, .rstn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.tx_in_valid, .tx_in, .tx_out_valid, .tx_out, .tx_freq_up,
		.tx_freq_dn, .rec_wr, .rec_addr, .meas_running, .interval_tick);
	fcei_far_port u_far (.ref_clk, .rstn, .tx_out_valid, .tx_out, .n_err,
		.n_os);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic end_of_test();
		if (mismatches == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got,
				exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		cmp_val(32'(s_axi_bresp), 32'(RESP_OK));
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		cmp_val(s_axi_rdata, d);
		cmp_val(32'(s_axi_rresp), 32'(r));
	endtask
	task automatic wait_run(input logic v, output int n);
		n = 0;
		while (meas_running !== v && n < 400)
		begin
			@(posedge ref_clk);
			n++;
		end
	endtask
	task automatic win(input int w, output int n);
		int e0;
		e0 = n_err;
		repeat (w) @(posedge ref_clk);
		n = n_err - e0;
	endtask
	always #20 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		n_up <= n_up + int'(tx_freq_up);
		n_dn <= n_dn + int'(tx_freq_dn);
		n_tick <= n_tick + int'(interval_tick);
		seed = lfsr(seed);
		tx_in_valid <= rstn;
		tx_in <= '{2'b01, {seed[31:1], ^seed[31:1]}, 4'h0, 1'b0, tags[2],
			tags[1], tags[0]};
		if (cyc == 30000)
		begin
			mismatches++;
			end_of_test();
		end
	end
	initial
	begin
		int n, p, w, t0;
		repeat (6) @(posedge ref_clk);
		rstn <= 1'b1;
		rdc(OFS_BURST, 32'h0000_0001, RESP_OK);
		rdc(8'h40, 32'h0000_0000, RESP_ERR);
		wr(OFS_BURST, 32'h0000_0003);
		rdc(OFS_BURST, 32'h0000_0003, RESP_OK);
		for (int a = 1; a <= 4; a++)
		begin
			wr(OFS_CTRL, 32'(a));
			repeat (4) @(posedge ref_clk);
			cmp_val(tx_out.data, alw[a-1]);
			cmp_val(32'(tx_out.k), 32'h0000_0008);
		end
		n = n_os;
		repeat (20) @(posedge ref_clk);
		cmp_val(32'(n_os - n), 32'h0000_0014);
		wr(OFS_CTRL, 32'h0000_0000);
		repeat (3) @(posedge ref_clk);
		n = n_os;
		repeat (20) @(posedge ref_clk);
		cmp_val(32'(n_os - n), 32'h0000_0000);
		for (int i = 0; i < 10; i++)
		begin
			tags <= et[i][3:1];
			wr(OFS_CTRL, 32'(ec[i]));
			// pending errors of the old setting may land right after the write
			repeat (6) @(posedge ref_clk);
			n = n_err;
			wr(OFS_CMD, 32'h0000_0001);
			repeat (20) @(posedge ref_clk);
			w = et[i][0] ? 3 : 0;
			cmp_val(n_err - n, w);
		end
		wr(OFS_BURST, 32'h0000_0002);
		tags <= 3'b100;
		for (int m = 2; m <= 9; m++)
		begin
			p = m == 2 ? SEC : m == 3 ? 10 * SEC : 10 ** (m - 2);
			w = p < 1000 ? 1000 : p <= 10000 ? p : 200;
			wr(OFS_CTRL, 32'h0000_0008 | (32'(m) << CTRL_INS));
			repeat (10) @(posedge ref_clk);
			win(w, n);
			cmp_val(32'(n), p <= 10000 ? 32'(2 * (w / p)) : '0);
		end
		wr(OFS_FREQ, 32'h0007_A120);
		repeat (10) @(posedge ref_clk);
		n = n_up;
		repeat (100) @(posedge ref_clk);
		cmp_val(32'(n_up - n), 32'(100 * 500000 / PPM_FULL));
		wr(OFS_FREQ, 32'hFFFC_2F70);
		repeat (10) @(posedge ref_clk);
		n = n_dn;
		repeat (100) @(posedge ref_clk);
		cmp_val(32'(n_dn - n), 32'(100 * 250000 / PPM_FULL));
		wr(OFS_MCFG, 32'h0000_0001);
		wr(OFS_CMD, 32'h0000_0002);
		wait_run(1'b1, n);
		cmp_val(32'(n <= 1), 32'h0000_0001);
		repeat (3)
		begin
			@(posedge ref_clk);
			rec_wr <= 1'b1;
			@(posedge ref_clk);
			rec_wr <= 1'b0;
		end
		repeat (2) @(posedge ref_clk);
		cmp_val(32'(rec_addr), 32'(3 * REC_BYTES));
		wr(OFS_CMD, 32'h0000_0004);
		wait_run(1'b0, n);
		cmp_val(32'(n <= 1), 32'h0000_0001);
		wr(OFS_DUR, 32'h0000_0003);
		wr(OFS_MCFG, 32'h0000_0081);
		t0 = n_tick;
		wr(OFS_CMD, 32'h0000_0002);
		wait_run(1'b1, n);
		wait_run(1'b0, n);
		cmp_val(32'(n >= 2 * SEC && n <= 3 * SEC + 1), 32'h0000_0001);
		cmp_val(32'(n_tick - t0 inside {[2:3]}), 32'h0000_0001);
		wr(OFS_TIME, 32'h0000_0000);
		wr(OFS_START, 32'h0000_0002);
		wr(OFS_MCFG, 32'h0000_0020);
		wr(OFS_CMD, 32'h0000_0002);
		wait_run(1'b1, n);
		cmp_val(32'(n > 1 && n <= 2 * SEC), 32'h0000_0001);
		wr(OFS_STOP, 32'h0000_0004);
		wr(OFS_MCFG, 32'h0000_0060);
		wait_run(1'b0, n);
		cmp_val(32'(n >= SEC && n <= 2 * SEC), 32'h0000_0001);
		wr(OFS_CMD, 32'h0000_0004);
		end_of_test();
	end
endmodule
`default_nettype wire
